// ==== include/dvc_pkg.sv ====
// Constants, types and the VID lookup shared by the dynamic core-voltage checker.
// ****************************************************************************
// ****************************************************************************
package dvc_pkg;

  // ****************************************************************************
  // Timing
  // ****************************************************************************
  localparam int CLK_HZ         = 25_000_000;
  localparam int CLK_PER_US     = CLK_HZ / 1_000_000;
  localparam int CHECK_PERIOD_MS = 100;
  localparam int WINDOW_US      = 1500;
  localparam int VID_CHANGE_US  = 5;
  localparam int SKEW_NS        = 400;
  localparam int CHECK_PERIOD_CYC = CHECK_PERIOD_MS * 1000 * CLK_PER_US;
  localparam int WINDOW_CYC     = WINDOW_US * CLK_PER_US;
  localparam int SKEW_CYC       = (SKEW_NS * CLK_PER_US + 999) / 1000;
  localparam int AVG_LOG2       = 8;

  // ****************************************************************************
  // Voltage scale: one unit is 6.25 mV
  // ****************************************************************************
  localparam int              VOLT_W    = 10;
  localparam logic [VOLT_W:0] UPPER_CAP = 11'h0fe;

  // ****************************************************************************
  // Register byte offsets and reset values
  // ****************************************************************************
  localparam logic [4:0] ADDR_CTRL   = 5'h00;
  localparam logic [4:0] ADDR_UP_OFS = 5'h04;
  localparam logic [4:0] ADDR_LO_OFS = 5'h08;
  localparam logic [4:0] ADDR_STATUS = 5'h0c;
  localparam logic [4:0] ADDR_AVG    = 5'h10;
  localparam logic [4:0] ADDR_CORE   = 5'h14;
  localparam logic [4:0] ADDR_AUX    = 5'h18;
  localparam logic [4:0] ADDR_VID    = 5'h1c;
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_MODE_LSB  = 1;
  localparam int CTRL_ROUTE_BIT = 3;
  localparam int ST_HIGH_BIT    = 0;
  localparam int ST_LOW_BIT     = 1;
  localparam int ST_SKIP_BIT    = 2;
  localparam int ST_UPDIS_BIT   = 3;
  localparam int ST_GPIO_BIT    = 4;
  localparam logic [3:0] CTRL_RST   = 4'h0;
  localparam logic [7:0] UP_OFS_RST = 8'h08;
  localparam logic [7:0] LO_OFS_RST = 8'h08;

  // ****************************************************************************
  // Types
  // ****************************************************************************
  typedef enum logic [1:0] {
    MODE_A  = 2'h0,
    MODE_B  = 2'h1,
    MODE_C  = 2'h2,
    MODE_CH = 2'h3
  } dvc_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_WINDOW  = 4'b0010,
    ST_WAIT    = 4'b0100,
    ST_COMPARE = 4'b1000
  } dvc_state_t;

  typedef struct packed {
    logic              valid;
    logic [VOLT_W-1:0] code;
  } dvc_sample_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } dvc_aux_t;

  typedef struct packed {
    logic              off;
    logic [VOLT_W-1:0] volt;
  } dvc_vref_t;

  // Maps a filtered VID code to its reference voltage and off flag.
  function automatic dvc_vref_t vid_lookup(input dvc_mode_t mode, input logic [6:0] code);
    dvc_vref_t r;
    r.off  = 1'b0;
    r.volt = '0;
    case (mode)
      MODE_A: begin
        r.off  = (code[5:0] >= 6'h3e);
        r.volt = r.off ? '0 : 10'h100 - {3'h0, code[5:0], 1'b0};
      end
      MODE_B: begin
        r.off  = (code >= 7'h7e);
        r.volt = r.off ? '0 : 10'h100 - {2'h0, code, 1'b0};
      end
      MODE_C: begin
        r.off  = (code < 7'h02);
        r.volt = r.off ? '0 : 10'h102 - {3'h0, code};
      end
      MODE_CH: begin
        r.off  = 1'b0;
        r.volt = 10'h082 - {3'h0, code};
      end
      default: begin
        r.off  = 1'b1;
        r.volt = '0;
      end
    endcase
    return r;
  endfunction

endpackage

// ==== design/dvc_core_checker.sv ====
// Dynamic VID-based core-voltage window checker with an Avalon-MM register slave.
`timescale 1ns/1ps
`default_nettype none

module dvc_core_checker #(
  parameter int CHECK_PERIOD_CYC = dvc_pkg::CHECK_PERIOD_CYC,
  parameter int WINDOW_CYC       = dvc_pkg::WINDOW_CYC,
  parameter int SKEW_CYC         = dvc_pkg::SKEW_CYC
) (
  input  wire logic            i_clk,
  input  wire logic            i_rst_n,
  input  wire logic [4:0]      i_avs_address,
  input  wire logic            i_avs_read,
  input  wire logic            i_avs_write,
  input  wire logic [31:0]     i_avs_writedata,
  input  wire logic [3:0]      i_avs_byteenable,
  output logic [31:0]          o_avs_readdata,
  output logic                 o_avs_waitrequest,
  input  wire logic [5:0]      i_voltage_id_inputs,
  input  wire logic            i_voltage_id_top_bit,
  input  wire dvc_pkg::dvc_sample_t i_core_rail_sense_input,
  input  wire dvc_pkg::dvc_aux_t    i_aux_temp_sense_input,
  output logic                 o_core_conv_req,
  output logic                 o_static_cmp_en,
  output logic                 o_vid_err_event,
  output dvc_pkg::dvc_aux_t    o_fan_temp
);

  localparam int PER_W   = $clog2(CHECK_PERIOD_CYC + 1);
  localparam int DIV     = (WINDOW_CYC >> dvc_pkg::AVG_LOG2) < 1 ? 1 :
                           (WINDOW_CYC >> dvc_pkg::AVG_LOG2);
  localparam int DIV_W   = $clog2(DIV + 1);
  localparam int SKEW_W  = $clog2(SKEW_CYC + 1);
  localparam int ACC_W   = dvc_pkg::VOLT_W + dvc_pkg::AVG_LOG2;
  localparam int NS_W    = dvc_pkg::AVG_LOG2 + 1;
  localparam logic [PER_W-1:0]  PER_LAST  = PER_W'(CHECK_PERIOD_CYC - 1);
  localparam logic [DIV_W-1:0]  DIV_LAST  = DIV_W'(DIV - 1);
  localparam logic [SKEW_W-1:0] SKEW_LAST = SKEW_W'(SKEW_CYC - 1);
  localparam logic [NS_W-1:0]   NS_FULL   = NS_W'(1 << dvc_pkg::AVG_LOG2);

  // ****************************************************************************
  // Registers
  // ****************************************************************************
  logic [3:0]                    ctrl_reg;
  logic [7:0]                    up_ofs_reg;
  logic [7:0]                    lo_ofs_reg;
  logic [2:0]                    sticky_reg;
  logic                          up_dis_reg;
  logic                          gpio_reg;
  logic [dvc_pkg::VOLT_W-1:0]    avg_reg;
  logic [dvc_pkg::VOLT_W-1:0]    core_reg;
  logic                          core_have_reg;
  logic [7:0]                    aux_reg;
  logic [6:0]                    cand_reg;
  logic [6:0]                    vid_reg;
  logic [SKEW_W-1:0]             skew_cnt_reg;
  logic [PER_W-1:0]              per_cnt_reg;
  logic [DIV_W-1:0]              div_cnt_reg;
  logic [NS_W-1:0]               nsamp_reg;
  logic [ACC_W-1:0]              acc_reg;
  logic                          off_seen_reg;
  logic                          ack_reg;
  dvc_pkg::dvc_state_t           state_reg;

  dvc_pkg::dvc_mode_t            mode;
  dvc_pkg::dvc_vref_t            vref;
  logic                          enable;
  logic                          period_tick;
  logic                          samp_tick;
  logic [6:0]                    vid_raw;
  logic [dvc_pkg::VOLT_W:0]      up_sum;
  logic [dvc_pkg::VOLT_W-1:0]    avg_now;
  logic [dvc_pkg::VOLT_W-1:0]    lo_lim;
  logic                          up_dis;
  logic                          hi_err;
  logic                          lo_err;
  logic                          do_cmp;
  logic                          bus_req;
  logic                          wr_take;
  logic                          rd_take;
  logic [2:0]                    set_bits;
  logic [31:0]                   rd_mux;

  assign mode   = dvc_pkg::dvc_mode_t'(ctrl_reg[dvc_pkg::CTRL_MODE_LSB +: 2]);
  assign enable = ctrl_reg[dvc_pkg::CTRL_EN_BIT];

  // ****************************************************************************
  // Avalon-MM slave: one wait cycle, then the access completes
  // ****************************************************************************
  assign bus_req           = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = bus_req & ~ack_reg;
  assign wr_take           = i_avs_write & ack_reg;
  assign rd_take           = i_avs_read & ~ack_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
    end
  end

  always_comb begin
    rd_mux = 32'h0;
    case (i_avs_address)
      dvc_pkg::ADDR_CTRL:   rd_mux = {28'h0, ctrl_reg};
      dvc_pkg::ADDR_UP_OFS: rd_mux = {24'h0, up_ofs_reg};
      dvc_pkg::ADDR_LO_OFS: rd_mux = {24'h0, lo_ofs_reg};
      dvc_pkg::ADDR_STATUS: rd_mux = {27'h0, gpio_reg, up_dis_reg, sticky_reg};
      dvc_pkg::ADDR_AVG:    rd_mux = {22'h0, avg_reg};
      dvc_pkg::ADDR_CORE:   rd_mux = {22'h0, core_reg};
      dvc_pkg::ADDR_AUX:    rd_mux = {24'h0, aux_reg};
      dvc_pkg::ADDR_VID:    rd_mux = {25'h0, vid_reg};
      default:              rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_avs_readdata <= 32'h0;
    end else if (rd_take) begin
      o_avs_readdata <= rd_mux;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_reg   <= dvc_pkg::CTRL_RST;
      up_ofs_reg <= dvc_pkg::UP_OFS_RST;
      lo_ofs_reg <= dvc_pkg::LO_OFS_RST;
    end else if (wr_take && i_avs_byteenable[0]) begin
      case (i_avs_address)
        dvc_pkg::ADDR_CTRL:   ctrl_reg   <= i_avs_writedata[3:0];
        dvc_pkg::ADDR_UP_OFS: up_ofs_reg <= i_avs_writedata[7:0];
        dvc_pkg::ADDR_LO_OFS: lo_ofs_reg <= i_avs_writedata[7:0];
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************************
  // VID capture and skew filter
  // ****************************************************************************
  // In mode A the side pin is only a general-purpose level, so it is masked out.
  assign vid_raw = {(mode != dvc_pkg::MODE_A) & i_voltage_id_top_bit,
                    i_voltage_id_inputs};

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gpio_reg <= 1'b0;
    end else begin
      gpio_reg <= (mode == dvc_pkg::MODE_A) & i_voltage_id_top_bit;
    end
  end

  // A code is accepted only after it has stood unchanged for the skew time, so
  // the short mixes seen while the lines switch never reach the averager.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cand_reg     <= 7'h0;
      vid_reg      <= 7'h0;
      skew_cnt_reg <= '0;
    end else if (vid_raw != cand_reg) begin
      cand_reg     <= vid_raw;
      skew_cnt_reg <= '0;
    end else if (skew_cnt_reg == SKEW_LAST) begin
      vid_reg      <= cand_reg;
    end else begin
      skew_cnt_reg <= skew_cnt_reg + 1'b1;
    end
  end

  assign vref = dvc_pkg::vid_lookup(mode, vid_reg);

  // ****************************************************************************
  // Check period and averaging sample strobe
  // ****************************************************************************
  assign period_tick = (per_cnt_reg == PER_LAST);
  assign samp_tick   = (div_cnt_reg == DIV_LAST);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      per_cnt_reg <= '0;
    end else if (period_tick) begin
      per_cnt_reg <= '0;
    end else begin
      per_cnt_reg <= per_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_cnt_reg <= '0;
    end else if (state_reg != dvc_pkg::ST_WINDOW || samp_tick) begin
      div_cnt_reg <= '0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 1'b1;
    end
  end

  // The static comparator elsewhere shares the same period strobe.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_static_cmp_en <= 1'b0;
      o_core_conv_req <= 1'b0;
    end else begin
      o_static_cmp_en <= period_tick;
      o_core_conv_req <= period_tick && enable && state_reg == dvc_pkg::ST_IDLE;
    end
  end

  // ****************************************************************************
  // Window sequencer
  // ****************************************************************************
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= dvc_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        dvc_pkg::ST_IDLE: begin
          if (period_tick && enable) begin
            state_reg <= dvc_pkg::ST_WINDOW;
          end
        end
        dvc_pkg::ST_WINDOW: begin
          if (samp_tick && nsamp_reg == NS_FULL - 1'b1) begin
            state_reg <= dvc_pkg::ST_WAIT;
          end
        end
        dvc_pkg::ST_WAIT: begin
          if (core_have_reg) begin
            state_reg <= dvc_pkg::ST_COMPARE;
          end
        end
        dvc_pkg::ST_COMPARE: state_reg <= dvc_pkg::ST_IDLE;
        default:             state_reg <= dvc_pkg::ST_IDLE;
      endcase
    end
  end

  // Fixed-count averaging: 2**AVG_LOG2 evenly spaced samples over the window.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_reg      <= '0;
      nsamp_reg    <= '0;
      off_seen_reg <= 1'b0;
    end else if (state_reg == dvc_pkg::ST_IDLE) begin
      acc_reg      <= '0;
      nsamp_reg    <= '0;
      off_seen_reg <= 1'b0;
    end else if (state_reg == dvc_pkg::ST_WINDOW && samp_tick) begin
      acc_reg      <= acc_reg + ACC_W'(vref.volt);
      nsamp_reg    <= nsamp_reg + 1'b1;
      off_seen_reg <= off_seen_reg | vref.off;
    end
  end

  // Conversion result is held until the window has closed.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      core_reg      <= '0;
      core_have_reg <= 1'b0;
    end else if (o_core_conv_req) begin
      core_have_reg <= 1'b0;
    end else if (i_core_rail_sense_input.valid && state_reg != dvc_pkg::ST_IDLE) begin
      core_reg      <= i_core_rail_sense_input.code;
      core_have_reg <= 1'b1;
    end
  end

  // ****************************************************************************
  // Limit comparison
  // ****************************************************************************
  assign avg_now = acc_reg[ACC_W-1 -: dvc_pkg::VOLT_W];
  assign up_sum  = {1'b0, avg_now} + {3'h0, up_ofs_reg};
  assign up_dis  = (up_sum > dvc_pkg::UPPER_CAP);
  assign lo_lim  = (avg_now > {2'h0, lo_ofs_reg}) ?
                   avg_now - {2'h0, lo_ofs_reg} : '0;
  assign do_cmp  = (state_reg == dvc_pkg::ST_COMPARE) && !off_seen_reg;
  assign hi_err  = do_cmp && !up_dis && ({1'b0, core_reg} > up_sum);
  assign lo_err  = do_cmp && (core_reg < lo_lim);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_vid_err_event <= 1'b0;
    end else begin
      o_vid_err_event <= hi_err | lo_err;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      avg_reg    <= '0;
      up_dis_reg <= 1'b0;
    end else if (state_reg == dvc_pkg::ST_COMPARE) begin
      avg_reg    <= avg_now;
      up_dis_reg <= up_dis;
    end
  end

  // The three sticky status flags are write-one-to-clear; a new event in the same cycle wins.
  assign set_bits = {(state_reg == dvc_pkg::ST_COMPARE) & off_seen_reg, lo_err, hi_err};

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sticky_reg <= 3'h0;
    end else if (wr_take && i_avs_byteenable[0] && i_avs_address == dvc_pkg::ADDR_STATUS) begin
      sticky_reg <= (sticky_reg & ~i_avs_writedata[2:0]) | set_bits;
    end else begin
      sticky_reg <= sticky_reg | set_bits;
    end
  end

  // ****************************************************************************
  // Auxiliary input as a signed temperature source
  // ****************************************************************************
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aux_reg    <= 8'h0;
      o_fan_temp <= '0;
    end else begin
      o_fan_temp.valid <= 1'b0;
      if (i_aux_temp_sense_input.valid) begin
        aux_reg <= {~i_aux_temp_sense_input.code[7],
                    i_aux_temp_sense_input.code[6:0]};
        if (ctrl_reg[dvc_pkg::CTRL_ROUTE_BIT]) begin
          o_fan_temp.valid <= 1'b1;
          o_fan_temp.code  <= {~i_aux_temp_sense_input.code[7],
                               i_aux_temp_sense_input.code[6:0]};
        end
      end
    end
  end

endmodule

`default_nettype wire

// ==== verif/dvc_core_checker_properties.sv ====
// Port-level concurrent checks for the dynamic core-voltage checker.
`timescale 1ns/1ps
`default_nettype none
module dvc_core_checker_properties #(
  parameter int CHECK_PERIOD_CYC = 4000,
  parameter int WINDOW_CYC       = 512,
  parameter int SKEW_CYC         = 2
) (
  input wire logic                 i_clk,
  input wire logic                 i_rst_n,
  input wire logic [4:0]           i_avs_address,
  input wire logic                 i_avs_read,
  input wire logic                 i_avs_write,
  input wire logic [31:0]          i_avs_writedata,
  input wire logic [3:0]           i_avs_byteenable,
  input wire logic [31:0]          o_avs_readdata,
  input wire logic                 o_avs_waitrequest,
  input wire logic [5:0]           i_voltage_id_inputs,
  input wire logic                 i_voltage_id_top_bit,
  input wire dvc_pkg::dvc_sample_t i_core_rail_sense_input,
  input wire dvc_pkg::dvc_aux_t    i_aux_temp_sense_input,
  input wire logic                 o_core_conv_req,
  input wire logic                 o_static_cmp_en,
  input wire logic                 o_vid_err_event,
  input wire dvc_pkg::dvc_aux_t    o_fan_temp
);
  // ****
  // Helper state: cycles since the last tick and since the window opened.
  // ****
  localparam int WIN = (WINDOW_CYC / 256) * 256;
  int   per_cnt;
  int   win_cnt;
  logic armed;
  logic seen;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      per_cnt <= 0;
      win_cnt <= 0;
    end else begin
      per_cnt <= o_static_cmp_en ? 0 : per_cnt + 1;
      win_cnt <= o_core_conv_req ? 0 : (win_cnt < WIN ? win_cnt + 1 : win_cnt);
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      armed <= 1'b0;
      seen  <= 1'b0;
    end else begin
      armed <= o_core_conv_req | (armed & ~o_vid_err_event);
      seen  <= ~o_core_conv_req & (seen | (armed & i_core_rail_sense_input.valid));
    end
  end
  // ****
  // Assertions
  // ****
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_tick_spacing: assert property (o_static_cmp_en |-> per_cnt >= CHECK_PERIOD_CYC - 2)
    else $error("period tick came early");
  a_tick_due: assert property (per_cnt <= CHECK_PERIOD_CYC + 1)
    else $error("period tick missing");
  a_conv_on_tick: assert property (o_core_conv_req |-> o_static_cmp_en)
    else $error("conversion request without a tick");
  a_conv_single: assert property (o_core_conv_req |=> !o_core_conv_req [*8])
    else $error("conversion request repeated");
  a_err_after_win: assert property (o_vid_err_event |-> armed && win_cnt >= WIN)
    else $error("error event before window end");
  a_err_needs_sample: assert property (o_vid_err_event |-> seen)
    else $error("error event without a core sample");
  a_err_pulse: assert property (o_vid_err_event |=> !o_vid_err_event)
    else $error("error event longer than one cycle");
  a_fan_signed: assert property (o_fan_temp.valid |->
    $past(i_aux_temp_sense_input.valid)
    && o_fan_temp.code == ($past(i_aux_temp_sense_input.code) ^ 8'h80))
    else $error("fan temperature not sign converted");
  a_bus_one_wait: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest)
    else $error("more than one wait cycle");
  c_err: cover property (o_core_conv_req ##[1:1000] o_vid_err_event);
  c_fan: cover property (o_fan_temp.valid);
  c_tick: cover property (o_static_cmp_en);
endmodule
bind dvc_core_checker dvc_core_checker_properties #(
  .CHECK_PERIOD_CYC(CHECK_PERIOD_CYC), .WINDOW_CYC(WINDOW_CYC), .SKEW_CYC(SKEW_CYC)
) u_props (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .i_voltage_id_inputs(i_voltage_id_inputs),
  .i_voltage_id_top_bit(i_voltage_id_top_bit),
  .i_core_rail_sense_input(i_core_rail_sense_input),
  .i_aux_temp_sense_input(i_aux_temp_sense_input), .o_core_conv_req(o_core_conv_req),
  .o_static_cmp_en(o_static_cmp_en), .o_vid_err_event(o_vid_err_event),
  .o_fan_temp(o_fan_temp)
);
`default_nettype wire

// ==== verif/dvc_vid_source.sv ====
// Behavioural processor VID source and core-rail sampler.
`timescale 1ns/1ps
`default_nettype none
module dvc_vid_source (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_conv_req,
  input  wire logic [6:0]   i_code_first,
  input  wire logic [6:0]   i_code_second,
  input  wire logic         i_glitch,
  input  wire logic [9:0]   i_core_level,
  output logic [5:0]        o_vid,
  output logic              o_top,
  output dvc_pkg::dvc_sample_t o_core
);
  int         cnt;
  logic [6:0] code;
  logic       core_valid;
  // Counts from the conversion request and parks at 600 until the next one.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= 0;
    end else if (i_conv_req) begin
      cnt <= 1;
    end else if (cnt != 0 && cnt < 600) begin
      cnt <= cnt + 1;
    end
  end
  // One code step in mid-window, far slower than the minimum change spacing.
  always_comb begin
    code = (cnt >= 256) ? i_code_second : i_code_first;
    if (i_glitch && cnt == 300) begin
      code = 7'h7f;
    end
  end
  assign {o_top, o_vid} = code;
  assign core_valid = (cnt == 530);
  // The sample lines carry the inverse of the reading when not valid.
  assign o_core = {core_valid, core_valid ? i_core_level : ~i_core_level};
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench for the dynamic core-voltage checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module testbench;
  logic                 clk, rst_n, rd, wr, top, glitch, conv_req, static_en, err_ev;
  logic [4:0]           adr;
  logic [31:0]          wdat, rdata, q;
  logic [3:0]           ben;
  logic [5:0]           vid;
  logic [6:0]           code_a, code_b;
  logic [9:0]           core_lvl;
  dvc_pkg::dvc_sample_t core;
  dvc_pkg::dvc_aux_t    aux_in, fan;
  int                   errors = 0, cmp_count = 0, cyc = 0, err_cnt = 0, fan_cnt = 0;
  wire logic            wreq_w;

  dvc_core_checker #(.CHECK_PERIOD_CYC(4000), .WINDOW_CYC(512), .SKEW_CYC(2)) dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdat), .i_avs_byteenable(ben), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq_w), .i_voltage_id_inputs(vid), .i_voltage_id_top_bit(top),
    .i_core_rail_sense_input(core), .i_aux_temp_sense_input(aux_in),
    .o_core_conv_req(conv_req), .o_static_cmp_en(static_en), .o_vid_err_event(err_ev),
    .o_fan_temp(fan));
  dvc_vid_source u_src (.i_clk(clk), .i_rst_n(rst_n), .i_conv_req(conv_req),
    .i_code_first(code_a), .i_code_second(code_b), .i_glitch(glitch),
    .i_core_level(core_lvl), .o_vid(vid), .o_top(top), .o_core(core));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Event counters and the hang limit.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (err_ev === 1'b1) err_cnt++;
    if (fan.valid === 1'b1) fan_cnt++;
    if (cyc == 90000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Holds the request until waitrequest is sampled low at a rising edge, then releases there.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    @(posedge clk);
    adr  <= a;
    wdat <= d;
    ben  <= b;
    rd   <= ~w;
    wr   <= w;
    @(posedge clk);
    while (wreq_w !== 1'b0) @(posedge clk);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [4:0] a, input logic [31:0] e, input string n);
    bus(1'b0, a, 32'h0, 4'hf);
    `CHK(n, e, q)
  endtask
  task automatic aux_pulse(input logic [7:0] c);
    @(posedge clk);
    aux_in.valid <= 1'b1;
    aux_in.code  <= c;
    @(posedge clk);
    aux_in.valid <= 1'b0;
    aux_in.code  <= ~c;
  endtask
  // One full check: enable, wait for the window and sample, then inspect and clear status.
  task automatic run_case(input logic [1:0] m, input logic [6:0] a, input logic [6:0] b,
                          input logic g, input logic [9:0] c, input logic [7:0] ofs,
                          input logic [7:0] st);
    int n0;
    code_a   <= a;
    code_b   <= b;
    glitch   <= g;
    core_lvl <= c;
    bus(1'b1, dvc_pkg::ADDR_UP_OFS, {24'h0, ofs}, 4'hf);
    bus(1'b1, dvc_pkg::ADDR_LO_OFS, {24'h0, ofs}, 4'hf);
    bus(1'b1, dvc_pkg::ADDR_CTRL, {29'h0, m, 1'b1}, 4'hf);
    n0 = err_cnt;
    while (conv_req !== 1'b1) @(negedge clk);
    repeat (700) @(negedge clk);
    bus(1'b1, dvc_pkg::ADDR_CTRL, {29'h0, m, 1'b0}, 4'hf);
    `CHK("err_event", (st[1:0] != 2'b00), ((err_cnt - n0) == 1))
    rchk(dvc_pkg::ADDR_STATUS, {24'h0, st}, "status");
    rchk(dvc_pkg::ADDR_VID, {25'h0, (m == 2'h0) ? {1'b0, b[5:0]} : b}, "vid");
    bus(1'b1, dvc_pkg::ADDR_STATUS, 32'h7, 4'hf);
    rchk(dvc_pkg::ADDR_STATUS, {24'h0, st & 8'h18}, "status_clr");
  endtask

  initial begin
    rst_n    = 1'b0;
    rd       = 1'b0;
    wr       = 1'b0;
    adr      = '0;
    wdat     = '0;
    ben      = '0;
    aux_in   = '0;
    code_a   = '0;
    code_b   = '0;
    glitch   = 1'b0;
    core_lvl = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rchk(dvc_pkg::ADDR_CTRL, 32'h0, "ctrl_rst");
    rchk(dvc_pkg::ADDR_UP_OFS, {24'h0, dvc_pkg::UP_OFS_RST}, "up_rst");
    rchk(dvc_pkg::ADDR_LO_OFS, {24'h0, dvc_pkg::LO_OFS_RST}, "lo_rst");
    rchk(dvc_pkg::ADDR_STATUS, 32'h0, "status_rst");
    bus(1'b1, dvc_pkg::ADDR_UP_OFS, 32'h33, 4'he);
    rchk(dvc_pkg::ADDR_UP_OFS, 32'h8, "up_lane_off");
    bus(1'b1, dvc_pkg::ADDR_VID, 32'h7f, 4'hf);
    rchk(dvc_pkg::ADDR_VID, 32'h0, "vid_ro");
    aux_pulse(8'h58);
    rchk(dvc_pkg::ADDR_AUX, 32'hd8, "aux_signed");
    bus(1'b1, dvc_pkg::ADDR_CTRL, 32'h8, 4'hf);
    aux_pulse(8'h85);
    rchk(dvc_pkg::ADDR_AUX, 32'h05, "aux_routed");
    `CHK("fan_pulses", 1, fan_cnt)
    run_case(2'h1, 7'h10, 7'h10, 1'b0, 10'd224, 8'h08, 8'h00);
    run_case(2'h1, 7'h10, 7'h10, 1'b0, 10'd233, 8'h08, 8'h01);
    run_case(2'h1, 7'h10, 7'h10, 1'b0, 10'd215, 8'h08, 8'h02);
    run_case(2'h0, 7'h45, 7'h45, 1'b0, 10'd255, 8'h08, 8'h11);
    run_case(2'h0, 7'h3f, 7'h3f, 1'b0, 10'd0, 8'h08, 8'h04);
    run_case(2'h2, 7'h00, 7'h00, 1'b0, 10'd0, 8'h08, 8'h04);
    run_case(2'h2, 7'h02, 7'h02, 1'b0, 10'd300, 8'h08, 8'h08);
    run_case(2'h3, 7'h10, 7'h10, 1'b0, 10'd100, 8'h08, 8'h02);
    run_case(2'h1, 7'h10, 7'h10, 1'b1, 10'd224, 8'h08, 8'h00);
    run_case(2'h1, 7'h10, 7'h20, 1'b0, 10'd208, 8'h04, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
